//--- bench/bcg_frame_model.sv
// Behavioural framing logic facing the check generator's byte streams.
// Assumes one caller of send at a time, entering at any point in a cycle.
`default_nettype none

module bcg_frame_model
(
  // Clock
  input  wire logic       clk_i,
  // Range bytes towards the block
  output var  logic       msg_valid_o,
  output var  logic [7:0] msg_data_o,
  output var  logic       msg_first_o,
  output var  logic       msg_last_o,
  input  wire logic       msg_ready_i,
  // Check bytes from the block
  input  wire logic       chk_valid_i,
  input  wire logic [7:0] chk_data_i,
  input  wire logic       chk_last_i,
  output var  logic       chk_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] got[$];  // Check bytes taken
  int         last_at; // Index that carried the last flag
  bit         stall;   // Consumer takes every other cycle

  // Idle levels at time zero
  initial
  begin
    msg_valid_o = 1'b0;
    msg_data_o  = 8'h00;
    msg_first_o = 1'b0;
    msg_last_o  = 1'b0;
    chk_ready_o = 1'b1;
    last_at     = -1;
  end

  // Holds each byte until taken; LRC callers keep the range even
  task automatic send(input logic [7:0] b[$], input bit mark);
    @(posedge clk_i);
    for (int i = 0; i < b.size(); i++)
    begin
      msg_valid_o <= 1'b1;
      msg_data_o  <= b[i];
      msg_first_o <= mark && (i == 0);
      msg_last_o  <= mark && (i == b.size() - 1);
      do @(posedge clk_i); while (msg_ready_i !== 1'b1);
    end
    msg_valid_o <= 1'b0;
    msg_first_o <= 1'b0;
    msg_last_o  <= 1'b0;
    msg_data_o  <= ~msg_data_o; // Released line does not keep its value
  endtask

  // Consumer of check bytes, optionally stalling
  always @(posedge clk_i)
  begin
    if (chk_valid_i && chk_ready_o)
    begin
      if (chk_last_i)
      begin
        last_at <= got.size();
      end
      got.push_back(chk_data_i);
    end
    chk_ready_o <= stall ? ~chk_ready_o : 1'b1;
  end
endmodule

`default_nettype wire

//--- bench/tb_bcg_top.sv
// Self-checking bench of the check generator: register tasks plus frame runs.
// Assumes the design answers each bus request and finishes each frame in a few cycles.
`default_nettype none

module tb_bcg_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bcg_pkg::*;

  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic msg_valid_i, msg_first_i, msg_last_i, msg_ready_o;
  logic [7:0] msg_data_i, chk_data_o;
  logic chk_valid_o, chk_last_o, chk_ready_i, done_o, mismatch_o, irq_o;
  int miscompares, checks_done;
  bit mask_on; // Interrupt mask currently open

  bcg_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .msg_valid_i(msg_valid_i), .msg_data_i(msg_data_i), .msg_first_i(msg_first_i), .msg_last_i(msg_last_i),
    .msg_ready_o(msg_ready_o), .chk_valid_o(chk_valid_o), .chk_data_o(chk_data_o), .chk_last_o(chk_last_o),
    .chk_ready_i(chk_ready_i), .done_o(done_o), .mismatch_o(mismatch_o), .irq_o(irq_o));
  bcg_frame_model mdl (.clk_i(clk_i), .msg_valid_o(msg_valid_i), .msg_data_o(msg_data_i),
    .msg_first_o(msg_first_i), .msg_last_o(msg_last_i), .msg_ready_i(msg_ready_o), .chk_valid_i(chk_valid_o),
    .chk_data_i(chk_data_o), .chk_last_i(chk_last_o), .chk_ready_o(chk_ready_i));

  // 250 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Comparison with count and report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    check(32'(n < 50), 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    check(q, e);
  endtask

  // Hex digit to upper-case character, and back
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n > 4'h9) ? ({4'h0, n} + 8'h37) : ({4'h0, n} + 8'h30);
  endfunction
  function automatic logic [3:0] nib(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : (c[3:0] + 4'h9);
  endfunction

  // Expected check bytes and check value
  task automatic exp_calc(input logic [7:0] ctrl, input logic [7:0] m[$], output logic [7:0] q[$],
                          output logic [15:0] v);
    logic [15:0] s;
    s = 16'h0;
    q = {};
    case (ctrl[1:0])
      BCG_FORM_LRC:
      begin
        for (int i = 0; i + 1 < m.size(); i += 2) s += {8'h0, nib(m[i]), nib(m[i+1])};
        v = ~s + 16'h1;
        q = {hx(v[7:4]), hx(v[3:0])};
      end
      BCG_FORM_RTU:
      begin
        s = 16'hFFFF;
        foreach (m[i])
        begin
          s ^= {8'h0, m[i]};
          repeat (8) s = s[0] ? ((s >> 1) ^ 16'hA001) : (s >> 1);
        end
        v = s;
        q = {s[7:0], s[15:8]};
      end
      default:
      begin
        foreach (m[i]) s += {8'h0, m[i]};
        v = ~s + 16'h1;
        for (int i = int'(ctrl[4:3]); i >= 0; i--)
          q.push_back(ctrl[2] ? hx(v[4*i+:4]) : ((i < 2) ? v[8*i+:8] : 8'h00));
      end
    endcase
  endtask

  // One frame: configure, feed range, take or feed the check field
  task automatic run(input logic [7:0] ctrl, input string txt, input bit stall, input bit bad);
    logic [7:0] m[$];
    logic [7:0] q[$];
    logic [15:0] v;
    int n;
    for (int i = 0; i < txt.len(); i++) m.push_back(txt[i]);
    exp_calc(ctrl, m, q, v);
    wr(BCG_ADR_CTRL, {24'h0, ctrl});
    mdl.got = {};
    mdl.last_at = -1;
    mdl.stall = stall;
    mdl.send(m, 1'b1);
    @(negedge clk_i);
    check({31'h0, msg_ready_o}, 32'h0);
    if (ctrl[5])
    begin
      if (bad) q[q.size()-1] ^= 8'h01;
      mdl.send(q, 1'b0);
    end
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (done_o !== 1'b1 && n < 300);
    check({31'h0, done_o}, 32'h1);
    if (!ctrl[5])
    begin
      check(32'(mdl.got.size()), 32'(q.size()));
      foreach (q[i]) check({24'h0, mdl.got[i]}, {24'h0, q[i]});
      check(32'(mdl.last_at), 32'(q.size() - 1));
    end
    @(negedge clk_i);
    check({31'h0, mismatch_o}, {31'h0, bad});
    check({31'h0, irq_o}, {31'h0, mask_on});
    rd(BCG_ADR_RESULT, {16'h0, v});
    rd(BCG_ADR_STATUS, {30'h0, bad, 1'b0});
    rd(BCG_ADR_IRQ_STAT, {30'h0, bad, 1'b1});
    wr(BCG_ADR_IRQ_STAT, 32'h3);
    @(negedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    $display("test ctrl=%h ended", ctrl);
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    logic [7:0]  one[$];
    logic [31:0] q;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(BCG_ADR_CTRL, 32'h0C);
    rd(BCG_ADR_IRQ_MASK, 32'h0);
    rd(BCG_ADR_STATUS, 32'h0);
    rd(8'h20, 32'h0);
    wb(1'b1, BCG_ADR_CTRL, 32'h3F, 4'hE, q);
    wr(BCG_ADR_STATUS, 32'h3);
    rd(BCG_ADR_CTRL, 32'h0C);
    rd(BCG_ADR_STATUS, 32'h0);
    $display("test registers ended");
    one = {8'h55};
    mdl.send(one, 1'b0); // Stray byte while idle is dropped
    run(8'h0C, "ABC", 1'b0, 1'b0);
    wr(BCG_ADR_IRQ_MASK, 32'h3);
    mask_on = 1'b1;
    run(8'h1C, "ABC", 1'b1, 1'b0);
    run(8'h08, "ABC", 1'b0, 1'b0);
    run(8'h00, "Z", 1'b1, 1'b0);
    run(8'h05, "0103000A", 1'b1, 1'b0);
    run(8'h02, "123456789", 1'b1, 1'b0);
    run(8'h22, "123456789", 1'b0, 1'b0);
    run(8'h25, "0103000A", 1'b0, 1'b1);
    run(8'h20, "ABC", 1'b0, 1'b1);
    run(8'h22, "1A", 1'b0, 1'b1);
    run(8'h02, "1A", 1'b0, 1'b0);
    end_sim();
  end
endmodule

`default_nettype wire

//--- rtl/bcg_crc_if.sv
// Interface between the sequencer and the cyclic check step.
// Assumes both ends sit in the same clock domain.
`default_nettype none

interface bcg_crc_if;
  logic [15:0] seed;    // Register with byte already mixed in
  logic [15:0] result;  // Register after eight shifts
  modport drv  (output seed, input result);
  modport step (input seed, output result);
endinterface

`default_nettype wire

//--- rtl/bcg_crc_step.sv
// Eight shift-and-XOR stages of the cyclic check, purely combinational.
// Assumes the caller has mixed the byte into the low bits of the seed.
`default_nettype none

module bcg_crc_step
  import bcg_pkg::*;
(
  // Seed in, result out
  bcg_crc_if.step crc_p
);

  // ****************************************************************
  // Shift chain
  // ****************************************************************
  logic [15:0] stage_w [0:BCG_CRC_STEPS];  // Value after each shift

  assign stage_w[0] = crc_p.seed;

  // One stage per shift; carry out selects the XOR
  for (genvar i = 0; i < BCG_CRC_STEPS; i++)
  begin : g_shift
    assign stage_w[i+1] = stage_w[i][0] ? ((stage_w[i] >> 1) ^ BCG_CRC_POLY)
                                        : (stage_w[i] >> 1);
  end

  assign crc_p.result = stage_w[BCG_CRC_STEPS];

endmodule

`default_nettype wire

//--- rtl/bcg_pkg.sv
// Constants, types and helper functions of the block check character generator.
// Assumes a single 250 MHz clock and a classic Wishbone register bus.
`default_nettype none

package bcg_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0]  BCG_ADR_CTRL     = 8'h00;  // Formula and options
  localparam logic [7:0]  BCG_ADR_STATUS   = 8'h04;  // Busy and mismatch
  localparam logic [7:0]  BCG_ADR_RESULT   = 8'h08;  // Last check value
  localparam logic [7:0]  BCG_ADR_IRQ_STAT = 8'h0C;  // Sticky events, write one to clear
  localparam logic [7:0]  BCG_ADR_IRQ_MASK = 8'h10;  // Event enables

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          BCG_CTRL_FORM_LO = 0;      // Formula, two bits
  localparam int          BCG_CTRL_ASCII   = 2;      // Binary to ASCII conversion
  localparam int          BCG_CTRL_DIG_LO  = 3;      // Digit count minus one, two bits
  localparam int          BCG_CTRL_RX      = 5;      // Receive direction
  localparam logic [7:0]  BCG_CTRL_RST     = 8'h0C;  // Additive, ASCII, two digits
  localparam int          BCG_EV_DONE      = 0;      // Check field finished
  localparam int          BCG_EV_MISM      = 1;      // Received check differs
  localparam logic [1:0]  BCG_MASK_RST     = 2'h0;   // All events masked

  // ****************************************************************
  // Formula codes and arithmetic constants
  // ****************************************************************
  localparam logic [1:0]  BCG_FORM_ADD     = 2'h0;   // Additive two's complement
  localparam logic [1:0]  BCG_FORM_LRC     = 2'h1;   // Longitudinal check
  localparam logic [1:0]  BCG_FORM_RTU     = 2'h2;   // Cyclic check
  localparam logic [15:0] BCG_CRC_INIT     = 16'hFFFF;  // Seed
  localparam logic [15:0] BCG_CRC_POLY     = 16'hA001;  // Reflected generator
  localparam int          BCG_CRC_STEPS    = 8;      // Shifts per byte
  localparam logic [1:0]  BCG_TWO_LAST     = 2'h1;   // Last index of a two byte field

  // Frame sequencer states
  typedef enum logic [1:0] {BCG_IDLE, BCG_ACC, BCG_FIN, BCG_EMIT} bcg_state_t;

  // ASCII hex character to nibble
  function automatic logic [3:0] bcg_hex2nib(input logic [7:0] c);
    logic [7:0] t;
    t = (c >= 8'h41) ? (c - 8'h37) : (c - 8'h30);
    if (c >= 8'h61)
    begin
      t = c - 8'h57;
    end
    return t[3:0];
  endfunction

  // Nibble to upper-case ASCII hex character
  function automatic logic [7:0] bcg_nib2hex(input logic [3:0] n);
    return (n > 4'h9) ? ({4'h0, n} + 8'h37) : ({4'h0, n} + 8'h30);
  endfunction

  // Bitwise reference of one byte of the cyclic check
  function automatic logic [15:0] bcg_crc_ref(input logic [15:0] c);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < BCG_CRC_STEPS; i++)
    begin
      r = r[0] ? ((r >> 1) ^ BCG_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

`default_nettype wire

//--- rtl/bcg_top.sv
// Block check character generator: absorbs a message range byte by byte,
// then sends the check field (transmit) or compares it (receive).
// Assumes the framing logic marks the first and last range byte and
// does not change the control register while a frame is in flight.
//
// Our own choices: the Wishbone register port and the address map.
`default_nettype none

module bcg_top
  import bcg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Message range bytes, and received check bytes on receive
  input  wire logic        msg_valid_i,
  input  wire logic [7:0]  msg_data_i,
  input  wire logic        msg_first_i,
  input  wire logic        msg_last_i,
  output logic             msg_ready_o,
  // Check field bytes on transmit
  output logic             chk_valid_o,
  output logic [7:0]       chk_data_o,
  output logic             chk_last_o,
  input  wire logic        chk_ready_i,
  // Status
  output var  logic        done_o,
  output var  logic        mismatch_o,
  output var  logic        irq_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  bcg_state_t  state_r, state_nxt;       // Frame sequencer
  logic [15:0] acc_r, acc_nxt;           // Sum or CRC register
  logic [3:0]  hi_nib_r;                 // First character of a pair
  logic        half_r;                   // A pair is half done
  logic [15:0] result_r;                 // Check value of last frame
  logic [7:0]  chk_byte_r [0:3];         // Check field bytes
  logic [1:0]  idx_r;                    // Current check byte
  logic [1:0]  last_r;                   // Index of final check byte
  logic [7:0]  ctrl_r;                   // Control register
  logic [1:0]  mask_r;                   // Interrupt mask
  logic [1:0]  irq_stat_r;               // Sticky events
  logic        ack_r;                    // Bus acknowledge
  logic [31:0] rdata_r;                  // Bus read data
  logic        done_r;                   // Frame finished pulse
  logic        mism_r;                   // Mismatch in this frame

  bcg_crc_if   crc_if ();                // Link to the shift chain

  // ****************************************************************
  // Control decode
  // ****************************************************************
  logic [1:0]  form_w;                   // Selected formula
  logic        rx_w;                     // Receive direction
  logic        asc_w;                    // Characters, not binary
  logic [1:0]  nlast_w;                  // Last index for this formula
  assign form_w  = ctrl_r[BCG_CTRL_FORM_LO +: 2];
  assign rx_w    = ctrl_r[BCG_CTRL_RX];
  assign asc_w   = (form_w == BCG_FORM_LRC) || ctrl_r[BCG_CTRL_ASCII];
  assign nlast_w = (form_w == BCG_FORM_ADD) ? ctrl_r[BCG_CTRL_DIG_LO +: 2] : BCG_TWO_LAST;

  // ****************************************************************
  // Byte intake
  // ****************************************************************
  logic        take_w;                   // Range byte accepted
  logic        half_now_w;               // Pair state for this byte
  logic [15:0] base_w;                   // Register before this byte
  logic [15:0] add_w;                    // Additive update
  logic [15:0] lrc_w;                    // Pair update
  logic [3:0]  nib_w;                    // Decoded character
  assign msg_ready_o = (state_r == BCG_IDLE) || (state_r == BCG_ACC) ||
                       ((state_r == BCG_EMIT) && rx_w);
  assign take_w      = msg_valid_i &&
                       ((state_r == BCG_ACC) || ((state_r == BCG_IDLE) && msg_first_i));
  assign half_now_w  = msg_first_i ? 1'b0 : half_r;
  assign base_w      = !msg_first_i ? acc_r :
                       (form_w == BCG_FORM_RTU) ? BCG_CRC_INIT : 16'h0000;
  assign add_w       = base_w + {8'h00, msg_data_i};
  assign nib_w       = bcg_hex2nib(msg_data_i);
  assign lrc_w       = half_now_w ? (base_w + {8'h00, hi_nib_r, nib_w}) : base_w;
  assign crc_if.seed = base_w ^ {8'h00, msg_data_i};

  bcg_crc_step u_crc (
    .crc_p (crc_if.step)
  );

  // Next register value by formula
  always_comb
  begin
    acc_nxt = acc_r;
    if (take_w)
    begin
      unique case (form_w)
        BCG_FORM_LRC: acc_nxt = lrc_w;
        BCG_FORM_RTU: acc_nxt = crc_if.result;
        default:      acc_nxt = add_w;
      endcase
    end
  end

  // ****************************************************************
  // Check value and field bytes
  // ****************************************************************
  logic [15:0] result_w;                 // Final check value
  logic [31:0] res32_w;                  // Widened for byte shifts
  logic [7:0]  byte_w [0:3];             // Field byte candidates
  assign result_w = (form_w == BCG_FORM_RTU) ? acc_r : (~acc_r + 16'h0001);
  assign res32_w  = {16'h0000, result_w};

  // One candidate per field position
  for (genvar k = 0; k < 4; k++)
  begin : g_byte
    logic [1:0] pos_w;                   // Significance of this position
    assign pos_w     = nlast_w - 2'(k);
    assign byte_w[k] = (form_w == BCG_FORM_RTU) ? 8'(res32_w >> (8 * k)) :
                       asc_w ? bcg_nib2hex(4'(res32_w >> ({3'h0, pos_w} * 5'h04))) :
                       8'(res32_w >> ({3'h0, pos_w} * 5'h08));
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic step_w;                          // Check byte consumed
  logic end_w;                           // Final check byte consumed
  logic miss_w;                          // Received byte differs
  assign step_w      = (state_r == BCG_EMIT) && (rx_w ? msg_valid_i : chk_ready_i);
  assign end_w       = step_w && (idx_r == last_r);
  assign miss_w      = (state_r == BCG_EMIT) && rx_w && msg_valid_i &&
                       (msg_data_i != chk_byte_r[idx_r]);
  assign chk_valid_o = (state_r == BCG_EMIT) && !rx_w;
  assign chk_data_o  = chk_byte_r[idx_r];
  assign chk_last_o  = (idx_r == last_r);

  // State transitions
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      BCG_IDLE, BCG_ACC:
      begin
        if (take_w)
        begin
          state_nxt = msg_last_i ? BCG_FIN : BCG_ACC;
        end
      end
      BCG_FIN:  state_nxt = BCG_EMIT;
      BCG_EMIT:
      begin
        if (end_w)
        begin
          state_nxt = BCG_IDLE;
        end
      end
    endcase
  end

  // Sequencer and accumulator registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r  <= BCG_IDLE;
      acc_r    <= 16'h0000;
      hi_nib_r <= 4'h0;
      half_r   <= 1'b0;
      idx_r    <= 2'h0;
    end
    else
    begin
      state_r  <= state_nxt;
      acc_r    <= acc_nxt;
      hi_nib_r <= (take_w && !half_now_w) ? nib_w : hi_nib_r;
      half_r   <= take_w ? !half_now_w : half_r;
      idx_r    <= (state_r == BCG_FIN) ? 2'h0 : (step_w ? idx_r + 2'h1 : idx_r);
    end
  end

  // Field capture at the end of the range
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      result_r <= 16'h0000;
      last_r   <= 2'h0;
      chk_byte_r <= '{default: 8'h00};
    end
    else if (state_r == BCG_FIN)
    begin
      result_r   <= result_w;
      last_r     <= nlast_w;
      chk_byte_r <= byte_w;
    end
  end

  // Frame flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_r <= 1'b0;
      mism_r <= 1'b0;
    end
    else
    begin
      done_r <= end_w;
      mism_r <= miss_w || (mism_r && !(take_w && msg_first_i));
    end
  end

  assign done_o     = done_r;
  assign mismatch_o = mism_r;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic        req_w;                    // Request waiting for ack
  logic        wr_w;                     // Write takes effect
  logic        hit_ctrl_w, hit_stat_w, hit_res_w, hit_irq_w, hit_mask_w;
  logic [31:0] rd_mux_w;                 // Read selection
  logic [1:0]  ev_w;                     // Event pulses
  logic [1:0]  w1c_w;                    // Bits cleared by software
  assign req_w      = wb_cyc_i && wb_stb_i;
  assign wr_w       = req_w && wb_we_i && ack_r && wb_sel_i[0];
  assign hit_ctrl_w = (wb_adr_i == BCG_ADR_CTRL);
  assign hit_stat_w = (wb_adr_i == BCG_ADR_STATUS);
  assign hit_res_w  = (wb_adr_i == BCG_ADR_RESULT);
  assign hit_irq_w  = (wb_adr_i == BCG_ADR_IRQ_STAT);
  assign hit_mask_w = (wb_adr_i == BCG_ADR_IRQ_MASK);
  assign rd_mux_w   = hit_ctrl_w ? {24'h000000, ctrl_r} :
                      hit_stat_w ? {30'h0, mism_r, state_r != BCG_IDLE} :
                      hit_res_w  ? {16'h0000, result_r} :
                      hit_irq_w  ? {30'h0, irq_stat_r} :
                      hit_mask_w ? {30'h0, mask_r} : 32'h00000000;
  assign ev_w       = {miss_w, end_w};
  assign w1c_w      = (wr_w && hit_irq_w) ? wb_dat_i[1:0] : 2'h0;
  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = rdata_r;
  assign irq_o      = |(irq_stat_r & mask_r);

  // Ack one cycle after the request, read data with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      ack_r   <= req_w && !ack_r;
      rdata_r <= (req_w && !ack_r) ? rd_mux_w : rdata_r;
    end
  end

  // Software registers; a new event beats a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r     <= BCG_CTRL_RST;
      mask_r     <= BCG_MASK_RST;
      irq_stat_r <= 2'h0;
    end
    else
    begin
      ctrl_r     <= (wr_w && hit_ctrl_w) ? wb_dat_i[7:0] : ctrl_r;
      mask_r     <= (wr_w && hit_mask_w) ? wb_dat_i[1:0] : mask_r;
      irq_stat_r <= (irq_stat_r & ~w1c_w) | ev_w;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_add_sum: assert property (
    take_w && (form_w == BCG_FORM_ADD) && !msg_first_i |=> acc_r == $past(acc_r) + {8'h00, $past(msg_data_i)})
    else $error("additive sum not updated");
  a_add_twos: assert property (
    (state_r == BCG_FIN) && (form_w != BCG_FORM_RTU) |=> result_r == 16'(~$past(acc_r) + 16'h0001))
    else $error("additive check not negated");
  a_field_len: assert property (
    (state_r == BCG_FIN) && (form_w == BCG_FORM_ADD) |=> last_r == ctrl_r[BCG_CTRL_DIG_LO +: 2])
    else $error("digit count wrong");
  a_ascii_order: assert property (
    (state_r == BCG_FIN) && (form_w == BCG_FORM_ADD) && ctrl_r[BCG_CTRL_ASCII] && (nlast_w == 2'h1)
    |=> chk_byte_r[0] == bcg_nib2hex(result_r[7:4]) && chk_byte_r[1] == bcg_nib2hex(result_r[3:0]))
    else $error("ascii digits out of order");
  a_lrc_pair: assert property (
    take_w && (form_w == BCG_FORM_LRC) && half_r && !msg_first_i
    |=> acc_r == $past(acc_r) + {8'h00, $past(hi_nib_r), bcg_hex2nib($past(msg_data_i))})
    else $error("lrc pair not summed");
  a_lrc_two: assert property (
    (state_r == BCG_FIN) && (form_w == BCG_FORM_LRC) |=> last_r == BCG_TWO_LAST ##1 state_r == BCG_EMIT)
    else $error("lrc field not two characters");
  a_crc_seed: assert property (
    take_w && (form_w == BCG_FORM_RTU) && msg_first_i
    |=> acc_r == bcg_crc_ref(BCG_CRC_INIT ^ {8'h00, $past(msg_data_i)}))
    else $error("crc seed wrong");
  a_crc_chain: assert property (
    take_w && (form_w == BCG_FORM_RTU) && !msg_first_i
    |=> acc_r == bcg_crc_ref($past(acc_r) ^ {8'h00, $past(msg_data_i)}))
    else $error("crc chaining wrong");
  a_crc_swap: assert property (
    (state_r == BCG_FIN) && (form_w == BCG_FORM_RTU) |=> chk_byte_r[0] == acc_r[7:0] && chk_byte_r[1] == acc_r[15:8])
    else $error("crc bytes not swapped");
  a_rx_mismatch: assert property (
    miss_w |=> mism_r && irq_stat_r[BCG_EV_MISM])
    else $error("mismatch not flagged");
  a_ack_pulse: assert property (
    ack_r |=> !ack_r)
    else $error("ack held two cycles");

  c_tx_frame: cover property (end_w && !rx_w);
  c_rx_miss:  cover property (miss_w ##[0:8] end_w);
  c_crc_done: cover property ((form_w == BCG_FORM_RTU) && end_w);

endmodule

`default_nettype wire
